/* mm_consts.vh */
// Constants for the module management control and timing block
`ifndef MM_CONSTS_VH
`define MM_CONSTS_VH
`define MM_CLK_MHZ     200
`define MM_INIT_MS     2000
`define MM_INIT_CYC    (`MM_INIT_MS * 1000 * `MM_CLK_MHZ)
`define MM_RST_US      2
`define MM_RST_CYC     (`MM_RST_US * `MM_CLK_MHZ)
`define MM_DEV_ADDR    7'h50
`define MM_B_STATUS    8'h02
`define MM_B_FLAGS     8'h03
`define MM_B_CTRL      8'h5d
`define MM_B_MASK      8'h64
`define MM_NR_BIT      0
`define MM_F_LOS       0
`define MM_F_TXF       1
`define MM_F_COND      2
`define MM_F_READY     3
`define MM_PD_BIT      0
`define MM_A_STATUS    8'h00
`define MM_A_INJECT    8'h04
`define MM_A_DEVADDR   8'h08
`define MM_RESP_OKAY   2'b00
`define MM_RESP_SLVERR 2'b10
`endif

/* mm_sync.v */
// Two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module mm_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock_in,
  input  wire             rstn_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // mm_sync

/* mm_timer.v */
// Loadable down counter with a done level at zero
`timescale 1ns/1ps
module mm_timer #(
  parameter WIDTH = 8
) (
  input  wire             clock_in,
  input  wire             rstn_in,
  input  wire             load_in,
  input  wire [WIDTH-1:0] value_in,
  output wire             done_out
);
  reg [WIDTH-1:0] count_reg;

  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (load_in) begin
      count_reg <= value_in;
    end else if (count_reg != {WIDTH{1'b0}}) begin
      count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign done_out = (count_reg == {WIDTH{1'b0}});
endmodule // mm_timer

/* mm_mgmt_ctrl.v */
// Management control, status, attention and 2-wire slave of the module
//
// Behaviour
// [R1] Full function after power-on within the init time: not-ready cleared, attention raised.
// [R2] A module clear held low beyond the minimum pulse resets the module.
// [R3] The 2-wire slave answers no later than the init time after power-on.
// [R4] Not-ready bit 0 of status byte 2 clears and attention asserts at init.
// [R5] After module clear rises, full function returns within the init time.
// [R6] Low-power request pin high lowers power level within 100 us.
// [R7] A triggering condition sets its flag and pulls attention low within 200 ms.
// [R8] Flags clear on read; attention releases within 500 us after the stop.
// [R9] Receive loss of signal sets its flag and attention within 100 ms.
// [R10] Transmitter fault sets its flag and attention within 200 ms.
// [R11] A set mask bit stops its source driving attention within 100 ms.
// [R12] A cleared mask bit resumes its source driving attention within 100 ms.
// [R13] Module select asserted: 2-wire answers start within 100 us.
// [R14] Module select released: 2-wire answers stop within 100 us.
// [R15] Power-down bit set by write enters lower power within 100 ms.
// [R16] Power-down bit cleared by write returns to full function within 300 ms.
// [R17] Write-triggered delays count from the clock fall after the write's stop.
// [R18] Host reads the flag bytes in one pass after attention asserts.
// [R19] Host treats monitor data as invalid while not-ready reads set.
// [R20] Host waits the serial readiness delay before any 2-wire transfer.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mm_consts.vh"
module mm_mgmt_ctrl #(
  parameter [28:0] INIT_CYCLES = `MM_INIT_CYC
) (
  input  wire        clock_in,
  input  wire        rstn_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_n_out,
  input  wire        module_select_in_n,
  input  wire        module_clear_in_n,
  input  wire        low_power_request_pin_in,
  input  wire        rx_los_in,
  input  wire        tx_fault_in,
  input  wire        flag_cond_in,
  output wire        attention_out_n,
  output wire        low_power_out,
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  output wire [1:0]  s_axi_bresp_out,
  output wire        s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0]  s_axi_rresp_out,
  output wire        s_axi_rvalid_out,
  input  wire        s_axi_rready_in
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_AACK = 3'd2;
  localparam [2:0] S_WR   = 3'd3;
  localparam [2:0] S_WACK = 3'd4;
  localparam [2:0] S_RD   = 3'd5;
  localparam [2:0] S_RACK = 3'd6;
  localparam [31:0] RST_CYC_FULL = `MM_RST_CYC;
  localparam [8:0]  RST_CYCLES   = RST_CYC_FULL[8:0];

  wire [4:0] pins_s;
  wire       scl_s   = pins_s[4];
  wire       sda_s   = pins_s[3];
  wire       sel_s_n = pins_s[2];
  wire       clr_s_n = pins_s[1];
  wire       lp_s    = pins_s[0];
  wire       rst_done;
  wire       init_done;

  reg        scl_q_reg;
  reg        sda_q_reg;
  reg        boot_reg;
  reg        in_reset_reg;
  reg        not_ready_reg;
  reg [2:0]  state_reg;
  reg [3:0]  bitcnt_reg;
  reg [7:0]  shift_reg;
  reg [7:0]  tx_reg;
  reg [7:0]  ptr_reg;
  reg        rw_reg;
  reg        first_reg;
  reg        nack_reg;
  reg        sda_oe_n_reg;
  reg        sda_reg;
  reg [3:0]  flags_reg;
  reg [3:0]  seen_reg;
  reg [3:0]  mask_reg;
  reg        pdown_reg;
  reg        attn_n_reg;
  reg        low_power_reg;
  reg [3:0]  inject_reg;
  reg [6:0]  dev_addr_reg;
  reg        aw_got_reg;
  reg        w_got_reg;
  reg [7:0]  awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  reg        rvalid_reg;
  reg [1:0]  rresp_reg;
  reg [31:0] rdata_reg;

  mm_sync #(
    .WIDTH (5)
  ) u_sync (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .async_in ({scl_in, sda_in, module_select_in_n, module_clear_in_n,
                low_power_request_pin_in}),
    .sync_out (pins_s)
  );

  // Low time of the module clear pin
  mm_timer #(
    .WIDTH (9)
  ) u_rst_filt (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .load_in  (clr_s_n),
    .value_in (RST_CYCLES),
    .done_out (rst_done)
  );

  wire init_load = boot_reg | in_reset_reg;

  mm_timer #(
    .WIDTH (29)
  ) u_init (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .load_in  (init_load),
    .value_in (INIT_CYCLES),
    .done_out (init_done)
  );

  wire hold_reset = ~clr_s_n & rst_done; // [R2]
  wire ready_evt  = not_ready_reg & init_done & ~init_load; // [R1] [R4] [R5]
  wire active     = ~not_ready_reg & ~sel_s_n & ~in_reset_reg; // [R3] [R13] [R14]
  wire start_c    = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  wire stop_c     = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  wire scl_rise   = scl_s & ~scl_q_reg;
  wire scl_fall   = ~scl_s & scl_q_reg;
  wire [3:0] set_vec = {ready_evt, flag_cond_in, tx_fault_in, rx_los_in} | inject_reg;

  // Byte map seen by the host
  function [7:0] map_byte;
    input [7:0] addr;
    begin
      case (addr)
        `MM_B_STATUS: map_byte = {7'h00, not_ready_reg};
        `MM_B_FLAGS:  map_byte = {4'h0, flags_reg};
        `MM_B_CTRL:   map_byte = {7'h00, pdown_reg};
        `MM_B_MASK:   map_byte = {4'h0, mask_reg};
        default:      map_byte = 8'h00;
      endcase
    end
  endfunction

  wire [7:0] rd_byte = map_byte(ptr_reg);

  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_q_reg     <= 1'b0;
      sda_q_reg     <= 1'b0;
      boot_reg      <= 1'b1;
      in_reset_reg  <= 1'b0;
      not_ready_reg <= 1'b1;
      attn_n_reg    <= 1'b1;
      low_power_reg <= 1'b0;
    end else begin
      scl_q_reg     <= scl_s;
      sda_q_reg     <= sda_s;
      boot_reg      <= 1'b0;
      in_reset_reg  <= hold_reset; // [R2]
      if (init_load) begin
        not_ready_reg <= 1'b1;
      end else if (ready_evt) begin
        not_ready_reg <= 1'b0; // [R1] [R4] [R5]
      end
      attn_n_reg    <= ~|(flags_reg & ~mask_reg); // [R7] [R11] [R12]
      low_power_reg <= lp_s | pdown_reg | in_reset_reg; // [R6] [R15] [R16]
    end
  end

  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg    <= S_IDLE;
      bitcnt_reg   <= 4'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      ptr_reg      <= 8'h00;
      rw_reg       <= 1'b0;
      first_reg    <= 1'b0;
      nack_reg     <= 1'b0;
      sda_oe_n_reg <= 1'b1;
      sda_reg      <= 1'b0;
      flags_reg    <= 4'h0;
      seen_reg     <= 4'h0;
      mask_reg     <= 4'h0;
      pdown_reg    <= 1'b0;
    end else if (in_reset_reg) begin
      state_reg    <= S_IDLE;
      sda_oe_n_reg <= 1'b1;
      flags_reg    <= 4'h0;
      seen_reg     <= 4'h0;
      mask_reg     <= 4'h0;
      pdown_reg    <= 1'b0;
    end else begin
      // Set wins over clear-on-read
      if (stop_c) begin
        flags_reg <= (flags_reg & ~seen_reg) | set_vec; // [R8]
        seen_reg  <= 4'h0;
      end else begin
        flags_reg <= flags_reg | set_vec; // [R7] [R9] [R10]
      end
      if (!active) begin
        state_reg    <= S_IDLE; // [R14]
        sda_oe_n_reg <= 1'b1;
      end else if (start_c) begin
        state_reg    <= S_ADDR;
        bitcnt_reg   <= 4'h0;
        sda_oe_n_reg <= 1'b1;
      end else if (stop_c) begin
        state_reg    <= S_IDLE; // [R17]
        sda_oe_n_reg <= 1'b1;
      end else if (scl_rise) begin
        if (state_reg == S_ADDR || state_reg == S_WR) begin
          shift_reg  <= {shift_reg[6:0], sda_s};
          bitcnt_reg <= bitcnt_reg + 4'h1;
        end else if (state_reg == S_RACK) begin
          nack_reg <= sda_s;
        end
      end else if (scl_fall) begin
        case (state_reg)
          S_ADDR: begin
            if (bitcnt_reg == 4'h8) begin
              if (shift_reg[7:1] == dev_addr_reg) begin
                sda_oe_n_reg <= 1'b0;
                rw_reg       <= shift_reg[0];
                state_reg    <= S_AACK;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_AACK, S_RACK: begin
            if (state_reg == S_RACK && nack_reg) begin
              sda_oe_n_reg <= 1'b1;
              state_reg    <= S_IDLE;
            end else if (state_reg == S_RACK || rw_reg) begin
              tx_reg       <= rd_byte;
              sda_oe_n_reg <= rd_byte[7];
              if (ptr_reg == `MM_B_FLAGS) begin
                seen_reg <= seen_reg | flags_reg; // [R8]
              end
              bitcnt_reg   <= 4'h0;
              state_reg    <= S_RD;
            end else begin
              sda_oe_n_reg <= 1'b1;
              bitcnt_reg   <= 4'h0;
              first_reg    <= 1'b1;
              state_reg    <= S_WR;
            end
          end
          S_WR: begin
            if (bitcnt_reg == 4'h8) begin
              sda_oe_n_reg <= 1'b0;
              state_reg    <= S_WACK;
              first_reg    <= 1'b0;
              if (first_reg) begin
                ptr_reg <= shift_reg;
              end else begin
                ptr_reg <= ptr_reg + 8'h01;
                if (ptr_reg == `MM_B_MASK) begin
                  mask_reg <= shift_reg[3:0]; // [R11] [R12]
                end
                if (ptr_reg == `MM_B_CTRL) begin
                  pdown_reg <= shift_reg[`MM_PD_BIT]; // [R15] [R16]
                end
              end
            end
          end
          S_WACK: begin
            sda_oe_n_reg <= 1'b1;
            bitcnt_reg   <= 4'h0;
            state_reg    <= S_WR;
          end
          S_RD: begin
            if (bitcnt_reg == 4'h7) begin
              sda_oe_n_reg <= 1'b1;
              ptr_reg      <= ptr_reg + 8'h01;
              state_reg    <= S_RACK;
            end else begin
              sda_oe_n_reg <= tx_reg[6];
              tx_reg       <= {tx_reg[6:0], 1'b0};
              bitcnt_reg   <= bitcnt_reg + 4'h1;
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Register bus slave
  wire wr_fire   = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire wr_inject = awaddr_reg == `MM_A_INJECT;
  wire wr_addr   = awaddr_reg == `MM_A_DEVADDR;

  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= `MM_RESP_OKAY;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= `MM_RESP_OKAY;
      rdata_reg    <= 32'h00000000;
      inject_reg   <= 4'h0;
      dev_addr_reg <= `MM_DEV_ADDR;
    end else begin
      inject_reg <= 4'h0;
      if (s_axi_awvalid_in && !aw_got_reg && !bvalid_reg) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_got_reg && !bvalid_reg) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        if (wr_inject && wstrb_reg[0]) begin
          inject_reg <= wdata_reg[3:0];
        end
        if (wr_addr && wstrb_reg[0]) begin
          dev_addr_reg <= wdata_reg[6:0];
        end
        if (wr_inject || wr_addr || awaddr_reg == `MM_A_STATUS) begin
          bresp_reg <= `MM_RESP_OKAY;
        end else begin
          bresp_reg <= `MM_RESP_SLVERR;
        end
      end else if (bvalid_reg && s_axi_bready_in) begin
        bvalid_reg <= 1'b0;
      end
      if (s_axi_arvalid_in && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= `MM_RESP_OKAY;
        case (s_axi_araddr_in)
          `MM_A_STATUS: rdata_reg <= {20'h00000, ~sel_s_n, pdown_reg, low_power_reg,
                                      mask_reg, flags_reg, not_ready_reg};
          `MM_A_INJECT: rdata_reg <= 32'h00000000;
          `MM_A_DEVADDR: rdata_reg <= {25'h0000000, dev_addr_reg};
          default: begin
            rdata_reg <= 32'h00000000;
            rresp_reg <= `MM_RESP_SLVERR;
          end
        endcase
      end else if (rvalid_reg && s_axi_rready_in) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign sda_out           = sda_reg;
  assign sda_oe_n_out      = sda_oe_n_reg;
  assign attention_out_n   = attn_n_reg;
  assign low_power_out     = low_power_reg;
  assign s_axi_awready_out = ~aw_got_reg & ~bvalid_reg;
  assign s_axi_wready_out  = ~w_got_reg & ~bvalid_reg;
  assign s_axi_bvalid_out  = bvalid_reg;
  assign s_axi_bresp_out   = bresp_reg;
  assign s_axi_arready_out = ~rvalid_reg;
  assign s_axi_rvalid_out  = rvalid_reg;
  assign s_axi_rresp_out   = rresp_reg;
  assign s_axi_rdata_out   = rdata_reg;
endmodule // mm_mgmt_ctrl

/* mm_mgmt_ctrl_assertions.sv */
// Port-level assertions for the management control block
`timescale 1ns/1ps
module mm_chk #(
  parameter [28:0] INIT_CYCLES = 29'd200
) (
  input        clock_in,
  input        rstn_in,
  input        module_select_in_n,
  input        module_clear_in_n,
  input        low_power_request_pin_in,
  input        sda_oe_n_out,
  input        attention_out_n,
  input        low_power_out,
  input        s_axi_awvalid_in,
  input        s_axi_awready_out,
  input        s_axi_wvalid_in,
  input        s_axi_wready_out,
  input [1:0]  s_axi_bresp_out,
  input        s_axi_bvalid_out,
  input        s_axi_bready_in,
  input        s_axi_arvalid_in,
  input        s_axi_arready_out,
  input [31:0] s_axi_rdata_out,
  input        s_axi_rvalid_out,
  input        s_axi_rready_in
);
  reg [15:0] clr_cnt_reg;
  reg [31:0] up_cnt_reg;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // Cycles of clear low, and cycles since release
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clr_cnt_reg <= 16'h0000;
      up_cnt_reg  <= 32'h0000_0000;
    end else begin
      if (module_clear_in_n)
        clr_cnt_reg <= 16'h0000;
      else if (clr_cnt_reg != 16'hffff)
        clr_cnt_reg <= clr_cnt_reg + 16'h0001;
      if (!module_clear_in_n)
        up_cnt_reg <= 32'h0000_0000;
      else if (up_cnt_reg < {3'b000, INIT_CYCLES} + 32'h40)
        up_cnt_reg <= up_cnt_reg + 32'h1;
    end
  end
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |=> ##1 s_axi_bvalid_out) else $error("write response late");
  a_bresp_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out) else $error("read data late");
  a_rdata_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_read_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while busy");
  a_lp_pin: assert property (low_power_request_pin_in [*6] |-> low_power_out)
    else $error("low power late");
  a_clear_reset: assert property (clr_cnt_reg > 16'd420
    |-> low_power_out && attention_out_n && sda_oe_n_out) else $error("clear ignored");
  a_select_off: assert property (module_select_in_n [*8] |=> sda_oe_n_out)
    else $error("drives while deselected");
  a_init_ready: assert property (up_cnt_reg == {3'b000, INIT_CYCLES} + 32'h20
    |-> !attention_out_n) else $error("not ready after init");
endmodule // mm_chk
bind mm_mgmt_ctrl mm_chk #(.INIT_CYCLES(INIT_CYCLES)) u_mm_chk (.clock_in, .rstn_in,
  .module_select_in_n, .module_clear_in_n, .low_power_request_pin_in, .sda_oe_n_out,
  .attention_out_n, .low_power_out, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
  .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in);

/* mm_host.sv */
// Behavioural 2-wire host with a 64 ns bit clock
`timescale 1ns/1ps
`include "mm_consts.vh"
module mm_host (
  input      sda_in,
  output reg scl_out,
  output reg sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task pb(input v);
    begin
      sda_low_out = ~v;
      #16 scl_out = 1'b1;
      #32 scl_out = 1'b0;
      #16;
    end
  endtask
  task gb(output v);
    begin
      sda_low_out = 1'b0;
      #16 scl_out = 1'b1;
      #16 v = sda_in;
      #16 scl_out = 1'b0;
      #16;
    end
  endtask
  task start;
    begin
      sda_low_out = 1'b0;
      #16 scl_out = 1'b1;
      #16 sda_low_out = 1'b1;
      #16 scl_out = 1'b0;
      #16;
    end
  endtask
  task stop;
    begin
      sda_low_out = 1'b1;
      #16 scl_out = 1'b1;
      #16 sda_low_out = 1'b0;
      #32;
    end
  endtask
  task wb(input [7:0] d, output ack);
    integer i;
    reg     a;
    begin
      for (i = 7; i >= 0; i = i - 1)
        pb(d[i]);
      gb(a);
      ack = ~a;
    end
  endtask
  // Pointer byte then one data byte, ended by stop
  task put(input [7:0] p, input [7:0] d, output ok);
    reg a0, a1, a2;
    begin
      start;
      wb({`MM_DEV_ADDR, 1'b0}, a0);
      wb(p, a1);
      wb(d, a2);
      stop;
      ok = a0 & a1 & a2;
    end
  endtask
  // One pass read from the pointer, host nack ends it
  task get(input [7:0] p, output [7:0] d, output ok);
    integer i;
    reg     a0, a1, a2, v;
    begin
      start;
      wb({`MM_DEV_ADDR, 1'b0}, a0);
      wb(p, a1);
      start;
      wb({`MM_DEV_ADDR, 1'b1}, a2);
      for (i = 7; i >= 0; i = i - 1) begin
        gb(v);
        d[i] = v;
      end
      pb(1'b1);
      stop;
      ok = a0 & a1 & a2;
    end
  endtask
endmodule // mm_host

/* mm_mgmt_ctrl_bench.sv */
// Self-checking bench for the management control block
`timescale 1ns/1ps
module mm_mgmt_ctrl_bench;
  localparam INIT = 200;
  reg         clock_in, rstn_in, module_select_in_n, module_clear_in_n;
  reg         low_power_request_pin_in, rx_los_in, tx_fault_in, flag_cond_in;
  reg  [7:0]  s_axi_awaddr_in, s_axi_araddr_in, b;
  reg  [31:0] s_axi_wdata_in, rnd;
  reg  [3:0]  s_axi_wstrb_in;
  reg         s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, ok;
  reg         s_axi_arvalid_in, s_axi_rready_in;
  wire        scl_in, sda_out, sda_oe_n_out, attention_out_n, low_power_out, h_low;
  wire        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  wire        s_axi_arready_out, s_axi_rvalid_out;
  wire [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire        sda_in = ~h_low & (sda_oe_n_out | sda_out);
  reg  [1:0]  exp_b[$];
  reg  [33:0] exp_r[$];
  integer     miscompares, comparisons, i;
  mm_mgmt_ctrl #(.INIT_CYCLES(INIT)) uut (.clock_in, .rstn_in, .scl_in, .sda_in, .sda_out,
    .sda_oe_n_out, .module_select_in_n, .module_clear_in_n, .low_power_request_pin_in,
    .rx_los_in, .tx_fault_in, .flag_cond_in, .attention_out_n, .low_power_out,
    .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in);
  mm_host host (.sda_in(sda_in), .scl_out(scl_in), .sda_low_out(h_low));
  function [31:0] lf(input [31:0] s);
    lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [33:0] g, input [33:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task chk1(input g, input e);
    chk({33'h0, g}, {33'h0, e});
  endtask
  task chkb(input [7:0] e);
    chk({25'h0, ok, b}, {25'h0, 1'b1, e});
  endtask
  task tally_and_finish;
    begin
      if (miscompares == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task axi_write(input [7:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      exp_b.push_back(r);
      @(posedge clock_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      for (n = 0; n < 50; n = n + 1) begin
        @(posedge clock_in);
        if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
        if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        if (s_axi_bvalid_out && s_axi_bready_in) n = 99;
        else if (s_axi_bvalid_out) s_axi_bready_in <= 1'b1;
      end
      if (n < 99) miscompares = miscompares + 1;
      s_axi_bready_in <= 1'b0;
    end
  endtask
  task axi_read(input [7:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      exp_r.push_back({r, d});
      @(posedge clock_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      for (n = 0; n < 50; n = n + 1) begin
        @(posedge clock_in);
        if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        if (s_axi_rvalid_out && s_axi_rready_in) n = 99;
        else if (s_axi_rvalid_out) s_axi_rready_in <= 1'b1;
      end
      if (n < 99) miscompares = miscompares + 1;
      s_axi_rready_in <= 1'b0;
    end
  endtask
  // Result watcher takes the oldest note per answer
  always @(posedge clock_in) begin
    if (s_axi_bvalid_out && s_axi_bready_in)
      chk({32'h0, s_axi_bresp_out}, {32'h0, exp_b.pop_front()});
    if (s_axi_rvalid_out && s_axi_rready_in)
      chk({s_axi_rresp_out, s_axi_rdata_out}, exp_r.pop_front());
  end
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial begin
    #200000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end
  initial begin
    {rstn_in, module_select_in_n, low_power_request_pin_in} = 3'b000;
    {rx_los_in, tx_fault_in, flag_cond_in, module_clear_in_n} = 4'b0001;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'b000;
    {s_axi_arvalid_in, s_axi_rready_in, s_axi_wstrb_in} = 6'h01;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
    miscompares = 0;
    comparisons = 0;
    rnd = 32'd82216;
    repeat (20) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (INIT + 40) @(posedge clock_in);
    chk1(attention_out_n, 1'b0);
    host.get(8'h02, b, ok);
    chkb(8'h00);
    axi_read(8'h00, 32'h810, 2'b00);
    host.get(8'h03, b, ok);
    chkb(8'h08);
    repeat (20) @(posedge clock_in);
    chk1(attention_out_n, 1'b1);
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge clock_in);
      {flag_cond_in, tx_fault_in, rx_los_in} <= 3'b001 << i;
      @(posedge clock_in);
      {flag_cond_in, tx_fault_in, rx_los_in} <= 3'b000;
      repeat (4) @(posedge clock_in);
      chk1(attention_out_n, 1'b0);
      host.get(8'h03, b, ok);
      chkb(8'h01 << i);
      repeat (20) @(posedge clock_in);
      chk1(attention_out_n, 1'b1);
    end
    host.put(8'h64, 8'h0f, ok);
    @(posedge clock_in);
    rx_los_in <= 1'b1;
    @(posedge clock_in);
    rx_los_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    chk1(attention_out_n, 1'b1);
    axi_read(8'h00, 32'h9e2, 2'b00);
    host.put(8'h64, 8'h00, ok);
    repeat (4) @(posedge clock_in);
    chk1(attention_out_n, 1'b0);
    host.get(8'h03, b, ok);
    chkb(8'h01);
    host.put(8'h5d, 8'h01, ok);
    repeat (4) @(posedge clock_in);
    chk1(low_power_out, 1'b1);
    axi_read(8'h00, 32'he00, 2'b00);
    host.put(8'h5d, 8'h00, ok);
    repeat (4) @(posedge clock_in);
    chk1(low_power_out, 1'b0);
    low_power_request_pin_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    chk1(low_power_out, 1'b1);
    low_power_request_pin_in <= 1'b0;
    module_select_in_n <= 1'b1;
    repeat (30) @(posedge clock_in);
    host.get(8'h02, b, ok);
    chk1(ok, 1'b0);
    module_select_in_n <= 1'b0;
    repeat (30) @(posedge clock_in);
    host.get(8'h02, b, ok);
    chkb(8'h00);
    rnd = lf(rnd);
    axi_write(8'h08, {25'h0, rnd[6:0]}, 2'b00);
    axi_read(8'h08, {25'h0, rnd[6:0]}, 2'b00);
    axi_write(8'h08, 32'h50, 2'b00);
    axi_write(8'h0c, rnd, 2'b10);
    axi_read(8'h0c, 32'h0, 2'b10);
    axi_write(8'h00, rnd, 2'b00);
    axi_write(8'h04, {28'h0, rnd[10:7]}, 2'b00);
    axi_read(8'h04, 32'h0, 2'b00);
    axi_read(8'h00, 32'h800 | {27'h0, rnd[10:7], 1'b0}, 2'b00);
    host.get(8'h03, b, ok);
    chkb({4'h0, rnd[10:7]});
    @(posedge clock_in);
    module_clear_in_n <= 1'b0;
    repeat (450) @(posedge clock_in);
    chk1(low_power_out, 1'b1);
    module_clear_in_n <= 1'b1;
    repeat (INIT + 40) @(posedge clock_in);
    chk1(attention_out_n, 1'b0);
    axi_read(8'h00, 32'h810, 2'b00);
    tally_and_finish;
  end
endmodule // mm_mgmt_ctrl_bench
